// >>> hw/lmb_pkg.sv
// Summary of operation
// - two local clocks, quarter period apart
// - all bus outputs follow the local clocks
// - ready low stalls cycle until high
// - each wait state is one full period
// - ready stretches read, write, transfer, refresh
// - internal cycles ignore the ready input
// - two active-low external interrupt request inputs
// - interrupt inputs synchronised before internal use
// - row then column address on bus
// - read data sampled late in cycle
// - write data driven late in cycle
// - bus bit 0 lsb, bit 15 msb
// - refresh flag low during row phase
// - transfer and fetch flags on column bits
// - fetch flag high only on instruction reads
// - write strobe low in write data and from row to end of transfer-from-SR cycles
// - direction low only while reading with enable
package lmb_pkg;

  // one local clock period is this many core clock cycles
  localparam int unsigned PHASES = 4;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_RAS_FALL = 2'h2;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RDATA = 8'h14;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned ADDR_ROW_LSB = 0;
  localparam int unsigned ADDR_COL_LSB = 16;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_RDY_BIT = 1;
  localparam int unsigned STAT_IRQ_LSB = 2;
  localparam int unsigned STAT_WAITS_LSB = 8;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] WDATA_RST = 16'h0000;
  localparam logic [15:0] BUS_IDLE = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [2:0] {
    K_READ = 3'h0,
    K_WRITE = 3'h1,
    K_FETCH = 3'h2,
    K_XFER_TO_SR = 3'h3,
    K_XFER_FROM_SR = 3'h4,
    K_REFRESH = 3'h5,
    K_INTERNAL = 3'h6
  } lmb_kind_type;

  typedef struct packed {
    lmb_kind_type kind;
    logic [14:0] row;
    logic [13:0] col;
    logic [15:0] wdata;
  } lmb_cycle_type;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic w_n;
    logic den_n;
    logic data_direction_out;
    logic lad_oe;
    logic [15:0] lad;
  } lmb_pins_type;

  localparam lmb_pins_type PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, w_n: 1'b1, den_n: 1'b1, data_direction_out: 1'b1,
                                         lad_oe: 1'b0, lad: 16'h0000};

endpackage : lmb_pkg

// >>> hw/lmb_sync.sv
`timescale 1ns/10ps
module lmb_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] agree;

  // first stage is read only by the second stage
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
    end
    else if (i_ce)
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign agree = ~(s2_reg ^ s3_reg);

  // a bit moves only once stages two and three agree
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      out_reg <= RST;
    else if (i_ce)
      out_reg <= (s2_reg & agree) | (out_reg & ~agree);
  end

  assign o_sync = out_reg;

  a_sync_agreed_change: assert property (@(posedge i_clk) disable iff (i_reset)
    (out_reg != $past(out_reg)) |-> ($past(s2_reg) == $past(s3_reg)))
    else $error("sync output moved without stage agreement");

endmodule : lmb_sync

// >>> hw/lmb_top.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module lmb_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_LOCAL_READY_IN,
  input wire logic I_EXT_IRQ_LINE_ONE_N,
  input wire logic I_EXT_IRQ_LINE_TWO_N,
  output logic [1:0] O_EXT_IRQ_PENDING,
  output logic O_LOCAL_CLOCK_PRIMARY,
  output logic O_LOCAL_CLOCK_QUADRATURE,
  output logic O_RAS_N,
  output logic O_CAS_N,
  output logic O_WRITE_STROBE_N,
  output logic O_DATA_BUFFER_ENABLE_N,
  output logic O_DATA_DIRECTION_OUT,
  input wire logic [15:0] I_ADDR_DATA_BUS,
  output logic [15:0] O_ADDR_DATA_BUS,
  output logic O_ADDR_DATA_BUS_OE
);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ROW = 6'h02,
    S_COL = 6'h04,
    S_DATA = 6'h08,
    S_WAIT = 6'h10,
    S_INT = 6'h20
  } lmb_state_type;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == lmb_pkg::OFF_CTRL) || (addr == lmb_pkg::OFF_ADDR) || (addr == lmb_pkg::OFF_WDATA) ||
                (addr == lmb_pkg::OFF_CMD) || (addr == lmb_pkg::OFF_STATUS) || (addr == lmb_pkg::OFF_RDATA);
  endfunction : is_mapped

  function automatic logic is_read_kind(input lmb_pkg::lmb_kind_type k);
    is_read_kind = (k == lmb_pkg::K_READ) || (k == lmb_pkg::K_FETCH);
  endfunction : is_read_kind

  logic [1:0] phase_reg;
  logic period_end;
  lmb_state_type state_reg;
  lmb_state_type state_next;
  lmb_pkg::lmb_cycle_type cur_reg;
  logic pend_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0] waits_reg;
  logic [31:0] prdata_reg;
  logic local_clock_primary_reg;
  logic local_clock_quadrature_reg;
  lmb_pkg::lmb_pins_type pins_reg;
  lmb_pkg::lmb_pins_type pins_next;
  logic [2:0] sync_out;
  logic rdy_s;
  logic bus_write;
  logic busy;
  logic data_phase;
  logic ready_done;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: ready and both interrupt lines

  lmb_sync #(
    .W(3),
    .RST(lmb_pkg::SYNC_RST)
  ) u_sync (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_ce(I_CE),
    .i_async({I_LOCAL_READY_IN, I_EXT_IRQ_LINE_TWO_N, I_EXT_IRQ_LINE_ONE_N}),
    .o_sync(sync_out)
  );

  assign rdy_s = sync_out[2];
  // requests are level held by the requester, so no latch is kept here
  assign O_EXT_IRQ_PENDING = ~sync_out[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // local clocks: four core cycles per period, quadrature lags by one

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      phase_reg <= 2'h0;
    else if (I_CE)
      phase_reg <= phase_reg + 2'h1;
  end

  assign period_end = (phase_reg == lmb_pkg::PH_LAST);

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      local_clock_primary_reg <= 1'b0;
      local_clock_quadrature_reg <= 1'b0;
    end
    else if (I_CE)
    begin
      local_clock_primary_reg <= (phase_reg == 2'h3) || (phase_reg == 2'h0);
      local_clock_quadrature_reg <= (phase_reg == 2'h0) || (phase_reg == 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign bus_write = I_PSEL && I_PENABLE && I_PWRITE && I_CE;
  assign busy = pend_reg || (state_reg != S_IDLE);
  assign O_PREADY = I_CE;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !is_mapped(I_PADDR);
  assign O_PRDATA = prdata_reg;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      ctrl_reg <= lmb_pkg::CTRL_RST;
      addr_reg <= lmb_pkg::ADDR_RST;
      wdata_reg <= lmb_pkg::WDATA_RST;
    end
    else if (bus_write)
    begin
      if (I_PADDR == lmb_pkg::OFF_CTRL)
        ctrl_reg <= {31'h0000_0000, I_PWDATA[lmb_pkg::CTRL_EN_BIT]};
      else if (I_PADDR == lmb_pkg::OFF_ADDR)
        addr_reg <= {2'h0, I_PWDATA[lmb_pkg::ADDR_COL_LSB +: 14], 1'b0, I_PWDATA[lmb_pkg::ADDR_ROW_LSB +: 15]};
      else if (I_PADDR == lmb_pkg::OFF_WDATA)
        wdata_reg <= I_PWDATA[15:0];
    end
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      prdata_reg <= 32'h0000_0000;
    else if (I_CE && I_PSEL && !I_PENABLE)
    begin
      if (I_PADDR == lmb_pkg::OFF_CTRL)
        prdata_reg <= ctrl_reg;
      else if (I_PADDR == lmb_pkg::OFF_ADDR)
        prdata_reg <= addr_reg;
      else if (I_PADDR == lmb_pkg::OFF_WDATA)
        prdata_reg <= {16'h0000, wdata_reg};
      else if (I_PADDR == lmb_pkg::OFF_STATUS)
        prdata_reg <= {16'h0000, waits_reg, 4'h0, ~sync_out[1:0], rdy_s, busy};
      else if (I_PADDR == lmb_pkg::OFF_RDATA)
        prdata_reg <= {16'h0000, rdata_reg};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  // a command while busy or disabled is dropped; software polls busy first
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      pend_reg <= 1'b0;
      cur_reg <= '{kind: lmb_pkg::K_INTERNAL, row: 15'h0000, col: 14'h0000, wdata: 16'h0000};
    end
    else if (I_CE)
    begin
      if (bus_write && (I_PADDR == lmb_pkg::OFF_CMD) && !busy && ctrl_reg[lmb_pkg::CTRL_EN_BIT])
      begin
        pend_reg <= 1'b1;
        cur_reg.kind <= lmb_pkg::lmb_kind_type'(I_PWDATA[2:0]);
        cur_reg.row <= addr_reg[lmb_pkg::ADDR_ROW_LSB +: 15];
        cur_reg.col <= addr_reg[lmb_pkg::ADDR_COL_LSB +: 14];
        cur_reg.wdata <= wdata_reg;
      end
      else if (period_end && (state_reg == S_IDLE))
        pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory cycle sequencer, one state per local clock period

  assign data_phase = (state_reg == S_DATA) || (state_reg == S_WAIT);
  assign ready_done = data_phase && period_end && rdy_s;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (pend_reg)
          state_next = (cur_reg.kind == lmb_pkg::K_INTERNAL) ? S_INT : S_ROW;
      S_ROW:
        state_next = S_COL;
      S_COL:
        state_next = S_DATA;
      S_DATA:
        state_next = rdy_s ? S_IDLE : S_WAIT;
      S_WAIT:
        state_next = rdy_s ? S_IDLE : S_WAIT;
      S_INT:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  // state only moves at a period boundary, so a wait is a whole period
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      state_reg <= S_IDLE;
    else if (I_CE && period_end)
      state_reg <= state_next;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      waits_reg <= 8'h00;
    else if (I_CE && period_end)
    begin
      if (state_reg == S_IDLE && pend_reg)
        waits_reg <= 8'h00;
      else if (data_phase && !rdy_s && (waits_reg != 8'hFF))
        waits_reg <= waits_reg + 8'h01;
    end
  end

  // sampled in the last core cycle of the final data period
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      rdata_reg <= 16'h0000;
    else if (I_CE && ready_done && is_read_kind(cur_reg.kind))
      rdata_reg <= I_ADDR_DATA_BUS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin values, registered on the core clock in step with the local clocks

  always_comb
  begin
    pins_next = lmb_pkg::PINS_IDLE;
    if (state_reg == S_ROW)
    begin
      pins_next.ras_n = (phase_reg < lmb_pkg::PH_RAS_FALL);
      pins_next.lad_oe = 1'b1;
      pins_next.lad = {cur_reg.kind != lmb_pkg::K_REFRESH, cur_reg.row};
    end
    else if (state_reg == S_COL)
    begin
      pins_next.ras_n = 1'b0;
      pins_next.lad_oe = 1'b1;
      pins_next.lad = {(cur_reg.kind != lmb_pkg::K_XFER_TO_SR) && (cur_reg.kind != lmb_pkg::K_XFER_FROM_SR),
                       cur_reg.kind == lmb_pkg::K_FETCH, cur_reg.col};
    end
    else if (data_phase)
    begin
      pins_next.ras_n = 1'b0;
      pins_next.cas_n = (cur_reg.kind == lmb_pkg::K_REFRESH);
      if (cur_reg.kind == lmb_pkg::K_WRITE)
      begin
        pins_next.lad_oe = 1'b1;
        pins_next.lad = cur_reg.wdata;
        pins_next.den_n = 1'b0;
        pins_next.w_n = 1'b0;
      end
      else if (is_read_kind(cur_reg.kind))
      begin
        pins_next.den_n = 1'b0;
        pins_next.data_direction_out = 1'b0;
      end
    end
    // transfer direction shows on the write strobe from row to end
    if ((cur_reg.kind == lmb_pkg::K_XFER_FROM_SR) && (state_reg != S_IDLE) && (state_reg != S_INT))
      pins_next.w_n = 1'b0;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      pins_reg <= lmb_pkg::PINS_IDLE;
    else if (I_CE)
      pins_reg <= pins_next;
  end

  assign O_LOCAL_CLOCK_PRIMARY = local_clock_primary_reg;
  assign O_LOCAL_CLOCK_QUADRATURE = local_clock_quadrature_reg;
  assign O_RAS_N = pins_reg.ras_n;
  assign O_CAS_N = pins_reg.cas_n;
  assign O_WRITE_STROBE_N = pins_reg.w_n;
  assign O_DATA_BUFFER_ENABLE_N = pins_reg.den_n;
  assign O_DATA_DIRECTION_OUT = pins_reg.data_direction_out;
  assign O_ADDR_DATA_BUS = pins_reg.lad;
  assign O_ADDR_DATA_BUS_OE = pins_reg.lad_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RESET);

  // the reset values break the lag on the second edge after release, so the first two edges are skipped
  a_clock_quadrature: assert property ((I_CE && $past(I_CE) && !$past(I_RESET, 2)) |->
    (local_clock_quadrature_reg == $past(local_clock_primary_reg)))
    else $error("quadrature clock does not lag primary by one core cycle");

  a_wait_period_len: assert property ((I_CE && state_reg != S_WAIT && state_next == S_WAIT && period_end)
    |=> (state_reg == S_WAIT) [*4])
    else $error("wait state shorter than a full local period");

  a_ready_low_stalls: assert property ((I_CE && data_phase && period_end && !rdy_s) |=> state_reg == S_WAIT)
    else $error("cycle ended while ready was low");

  a_ready_high_ends: assert property ((I_CE && data_phase && period_end && rdy_s) |=> state_reg == S_IDLE)
    else $error("cycle did not end after ready returned");

  a_internal_no_wait: assert property ((I_CE && state_reg == S_INT && period_end) |=> state_reg == S_IDLE)
    else $error("internal cycle was stretched");

  a_row_then_col: assert property ((I_CE && state_reg == S_ROW && period_end) |=> state_reg == S_COL)
    else $error("column phase did not follow row phase");

  a_refresh_flag_low: assert property ((I_CE && state_reg == S_ROW && cur_reg.kind == lmb_pkg::K_REFRESH)
    |=> (O_ADDR_DATA_BUS[15] == 1'b0 && O_ADDR_DATA_BUS_OE))
    else $error("refresh flag not low during row address");

  a_fetch_flag_only: assert property ((I_CE && state_reg == S_COL)
    |=> (O_ADDR_DATA_BUS[14] == $past(cur_reg.kind == lmb_pkg::K_FETCH)))
    else $error("fetch flag wrong during column address");

  a_write_strobe_cas: assert property ((!O_WRITE_STROBE_N && !O_CAS_N) |->
    (O_DATA_DIRECTION_OUT && (O_ADDR_DATA_BUS_OE == !O_DATA_BUFFER_ENABLE_N)))
    else $error("write strobe low outside a write data phase");

  a_direction_read: assert property (!O_DATA_DIRECTION_OUT |-> (!O_DATA_BUFFER_ENABLE_N && !O_ADDR_DATA_BUS_OE))
    else $error("direction low without a read data phase");

  c_read_cycle: cover property (ready_done && cur_reg.kind == lmb_pkg::K_READ);
  c_write_waited: cover property (state_reg == S_WAIT && cur_reg.kind == lmb_pkg::K_WRITE);
  c_refresh_cycle: cover property (ready_done && cur_reg.kind == lmb_pkg::K_REFRESH);
  c_internal_cycle: cover property (state_reg == S_INT);

endmodule : lmb_top

// >>> testbench/lmb_mem_model.sv
`timescale 1ns/10ps
module lmb_mem_model (
  input wire logic i_clk,
  input wire logic i_lclk,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_w_n,
  input wire logic i_den_n,
  input wire logic i_data_direction_out,
  input wire logic i_oe,
  input wire logic [15:0] i_bus,
  input wire logic [3:0] i_stall,
  output logic [15:0] o_bus,
  output logic o_rdy,
  output logic [15:0] o_row,
  output logic [15:0] o_col,
  output logic [7:0] o_cas_len,
  output logic [7:0] o_ras_cnt
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [15:0] bus_q;
  logic ras_q = 1'b1, cas_q = 1'b1, lclk_q = 1'b0;
  logic [3:0] left = 4'h0;
  initial
  begin
    o_rdy = 1'b1;
    o_ras_cnt = 8'h00;
    o_cas_len = 8'h00;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // off-bus the line shows a changing pattern, never a stale word
  assign o_bus = (i_den_n === 1'b0 && i_data_direction_out === 1'b0) ? mem[o_col[3:0]] : ~last;
  always @(posedge i_clk)
  begin
    ras_q <= i_ras_n;
    cas_q <= i_cas_n;
    lclk_q <= i_lclk;
    bus_q <= i_bus;
    last <= o_bus;
    if (ras_q && !i_ras_n)
    begin
      o_row <= i_bus;
      o_ras_cnt <= o_ras_cnt + 8'h01;
      left <= i_stall + 4'h2;
      if (i_stall != 4'h0) o_rdy <= 1'b0;
    end
    else if (!lclk_q && i_lclk && left != 4'h0)
    begin
      left <= left - 4'h1;
      // stall is bounded so refresh and transfers still get through
      if (left == 4'h1) o_rdy <= 1'b1;
    end
    // the column word sits on the bus the cycle before the column strobe
    if (cas_q && !i_cas_n) o_col <= bus_q;
    if (!i_cas_n) o_cas_len <= cas_q ? 8'h01 : o_cas_len + 8'h01;
    if (!cas_q && !i_cas_n && !i_w_n && i_oe) mem[o_col[3:0]] <= i_bus;
  end
endmodule : lmb_mem_model

// >>> testbench/test_local_memory_bus_interface.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("Error %0t mismatch", $time); end end
module test_local_memory_bus_interface;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, chk_on = 1'b0, hold = 1'b0;
  logic irq1_n = 1'b1, irq2_n = 1'b1, p1 = 1'b0, p2 = 1'b0, m_rdy;
  logic pready, pslverr, lc1, lc2, ras_n, cas_n, w_n, den_n, data_direction_out, oe;
  logic [7:0] paddr = 8'h00;
  logic [7:0] cas_len, ras_cnt, w;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] bus_o, bus_i, row_w, col_w, d;
  logic [14:0] row;
  logic [13:0] col;
  logic [3:0] stall = 4'h0;
  logic [2:0] kind = 3'h6;
  logic [1:0] pend;
  logic [32:0] q[$];
  int err_total = 0, n_tests = 0, cyc = 0, run = 0;
  always #20 clk = ~clk;
  lmb_top dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_LOCAL_READY_IN(m_rdy & ~hold), .I_EXT_IRQ_LINE_ONE_N(irq1_n), .I_EXT_IRQ_LINE_TWO_N(irq2_n),
    .O_EXT_IRQ_PENDING(pend), .O_LOCAL_CLOCK_PRIMARY(lc1), .O_LOCAL_CLOCK_QUADRATURE(lc2), .O_RAS_N(ras_n),
    .O_CAS_N(cas_n), .O_WRITE_STROBE_N(w_n), .O_DATA_BUFFER_ENABLE_N(den_n), .O_DATA_DIRECTION_OUT(data_direction_out),
    .I_ADDR_DATA_BUS(bus_i), .O_ADDR_DATA_BUS(bus_o), .O_ADDR_DATA_BUS_OE(oe));
  lmb_mem_model mem (.i_clk(clk), .i_lclk(lc1), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_w_n(w_n), .i_den_n(den_n),
    .i_data_direction_out(data_direction_out), .i_oe(oe), .i_bus(bus_o), .i_stall(stall), .o_bus(bus_i), .o_rdy(m_rdy), .o_row(row_w),
    .o_col(col_w), .o_cas_len(cas_len), .o_ras_cnt(ras_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat, input logic c,
    input logic [32:0] ex, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= dat;
    chk_on <= c;
    if (c) q.push_back(ex);
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge so the next call never re-raises psel in this time step
    @(posedge clk);
  endtask : apb
  task automatic mem_cycle(input logic [2:0] k, input logic [3:0] st);
    logic [31:0] s;
    logic [7:0] rc;
    int n;
    kind = k;
    stall <= st;
    rc = ras_cnt;
    row = 15'($urandom);
    apb(1'b1, 8'h04, {2'b00, col, 1'b0, row}, 1'b0, 33'h0, s);
    apb(1'b1, 8'h0C, {29'h0, k}, 1'b0, 33'h0, s);
    n = 0;
    s = 32'h0000_0001;
    while (s[0] !== 1'b0 && n < 200)
    begin
      apb(1'b0, 8'h10, 32'h0, 1'b0, 33'h0, s);
      n++;
    end
    `CHK(n < 200, 1'b1)
    w = s[15:8];
    if (k == 3'h6) `CHK({ras_cnt, w}, {rc, 8'h00})
    else
    begin
      `CHK(row_w, {k != 3'h5, row})
      `CHK(w + 8'h01 >= 8'(st) && w <= 8'(st) + 8'h01, 1'b1)
    end
    if (k < 3'h5) `CHK(col_w, {k != 3'h3 && k != 3'h4, k == 3'h2, col})
    if (k < 3'h3) `CHK(cas_len, 8'h04 * (w + 8'h01))
  endtask : mem_cycle
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    p1 <= lc1;
    p2 <= p1;
    run <= rst ? 0 : run + 1;
    cyc++;
    if (cyc > 8000)
    begin
      err_total++;
      report_and_stop();
    end
    if (psel && pen && pready === 1'b1 && !pwr && chk_on)
    begin
      `CHK({pslverr, prdata}, q[0])
      void'(q.pop_front());
    end
    if (run > 8)
    begin
      `CHK({lc1, lc2}, {~p2, p1})
      if (data_direction_out === 1'b0) `CHK(den_n, 1'b0)
      if (cas_n === 1'b0 && (kind == 3'h0 || kind == 3'h2)) `CHK(w_n, 1'b1)
      if (w_n === 1'b0 && kind != 3'h4) `CHK(cas_n, 1'b0)
    end
  end
  initial
  begin
    void'($urandom(32'hA89B));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(pend, 2'b00)
    apb(1'b0, 8'h00, 32'h0, 1'b1, {1'b0, lmb_pkg::CTRL_RST}, rd);
    apb(1'b0, 8'h10, 32'h0, 1'b1, 33'h0_0000_0002, rd);
    apb(1'b0, 8'h0C, 32'h0, 1'b1, 33'h0, rd);
    apb(1'b0, 8'h18, 32'h0, 1'b1, {1'b1, 32'h0}, rd);
    apb(1'b1, 8'h00, 32'h1, 1'b0, 33'h0, rd);
    d = 16'($urandom);
    col = 14'($urandom);
    apb(1'b1, 8'h08, {16'h0, d}, 1'b0, 33'h0, rd);
    mem_cycle(3'h1, 4'h0);
    mem_cycle(3'h0, 4'h2);
    apb(1'b0, 8'h14, 32'h0, 1'b1, {17'h0, d}, rd);
    mem_cycle(3'h2, 4'h1);
    apb(1'b0, 8'h14, 32'h0, 1'b1, {17'h0, d}, rd);
    for (int k = 3; k < 6; k++) mem_cycle(3'(k), 4'(k % 3));
    hold <= 1'b1;
    mem_cycle(3'h6, 4'h0);
    hold <= 1'b0;
    // requester keeps the line low until it shows as pending
    irq1_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(pend, 2'b00)
    repeat (8) @(posedge clk);
    `CHK(pend, 2'b01)
    irq2_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(pend, 2'b11)
    irq1_n <= 1'b1;
    irq2_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(pend, 2'b00)
    report_and_stop();
  end
endmodule : test_local_memory_bus_interface
